// file: hw/fps_top.sv
// Fixed position setpoint selection and position tracking logic
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"
// Behaviour
// RL1 - Target index is select inputs as binary, bit two highest, plus one.
// RL2 - Unmapped third select input reads low, limiting targets to one..four.
// RL3 - Each trigger rising edge starts a move to the selected target.
// RL4 - Enabled step-forward edge moves to the next higher target.
// RL5 - Enabled step-backward edge moves to the next lower target.
// RL6 - Enabled step-home edge moves to target one.
// RL7 - Step edges act only at standstill, never during motion.
// RL8 - Step-forward is ignored at target eight.
// RL9 - At target one step-backward is ignored, step-home still acts.
// RL10 - A move ending early still sets current target to commanded one.
// RL11 - With tracking, position is stored at power-off, read at power-on.
// RL12 - Range is resolution, times virtual turns when tracking is on.
// RL13 - Actual position value is held to thirty-two bits.
// RL14 - Power-up check: within quarter turn restore, else tracking fault.
// RL15 - Non-integer multi-turn over modulo ratio raises ratio fault.
// RL16 - Ratio formula depends on encoder kind and tracking setting.
// RL17 - Default map: select bits on inputs seven, eight; trigger on six.
// RL18 - Edges come from synchronised sample versus previous sample.
// RL19 - Step edges during motion are dropped, not queued.
module fps_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] digital_in,
    input wire logic power_fail,
    input wire logic motion_busy,
    input wire logic motor_standstill,
    input wire logic [31:0] enc_pos,
    input wire logic [31:0] nv_rd_data,
    input wire fps_pkg::fps_bus_t bus,
    output logic [31:0] rd_data,
    output fps_pkg::fps_move_t move,
    output fps_pkg::fps_nv_t nv,
    output logic tracking_tolerance_fault,
    output logic ratio_fault,
    output logic irq
);
    import fps_pkg::*;

    fps_state_t r_q;
    fps_state_t r_d;
    logic [7:0] di_s;
    logic pwr_s;
    logic ratio_bad;

    fps_sync #(.W(`FPS_IN_COUNT)) u_di_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(digital_in),
        .dout(di_s)
    );

    fps_sync #(.W(1)) u_pwr_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(power_fail),
        .dout(pwr_s)
    );

    fps_ratio_check u_ratio (
        .cfg(r_q.cfg),
        .ratio_bad(ratio_bad)
    );

    function automatic logic pick(input logic [7:0] di, input logic [3:0] idx);
        return (idx != 4'h0 && idx <= 4'h8) ? di[3'(idx - 4'h1)] : 1'b0;
    endfunction

    // Mapped input levels and their rising edges
    logic [2:0] sel;
    logic [3:0] sel_idx;
    logic [3:0] lvl;
    logic [3:0] rise;
    logic trg_rise;
    logic fwd_ok;
    logic back_ok;
    logic home_ok;
    logic step_gate;
    logic pwr_rise;
    logic check_fail;
    logic [32:0] diff;
    logic [32:0] quarter;

    always_comb begin
        sel[0] = pick(di_s, r_q.cfg.map.sel0);
        sel[1] = pick(di_s, r_q.cfg.map.sel1);
        sel[2] = pick(di_s, r_q.cfg.map.sel2); // RL2
        sel_idx = {1'b0, sel} + 4'h1; // RL1
        lvl[0] = pick(di_s, r_q.cfg.map.trg);
        lvl[1] = pick(di_s, r_q.cfg.map.step_forward);
        lvl[2] = pick(di_s, r_q.cfg.map.step_backward);
        lvl[3] = pick(di_s, r_q.cfg.map.step_home);
        rise = lvl & ~r_q.prev_in; // RL18
        trg_rise = rise[0];
        pwr_rise = pwr_s & ~r_q.prev_pwr;
        step_gate = (r_q.mode == FPS_IDLE) && motor_standstill; // RL7 RL19
        home_ok = step_gate && rise[3] && r_q.cfg.step_home_en; // RL6 RL9
        fwd_ok = step_gate && rise[1] && r_q.cfg.step_forward_en
            && (r_q.cur_tgt != `FPS_TGT_LAST); // RL8
        back_ok = step_gate && rise[2] && r_q.cfg.step_backward_en
            && (r_q.cur_tgt != `FPS_TGT_FIRST); // RL9
        diff = {1'b0, enc_pos} - {1'b0, nv_rd_data};
        if (diff[32]) begin
            diff = 33'h0 - diff;
        end
        quarter = {1'b0, r_q.cfg.res >> `FPS_QUARTER_SHIFT};
        check_fail = diff > quarter;
    end

    logic [63:0] range_full;
    logic signed [33:0] delta;
    logic signed [33:0] half;
    logic signed [33:0] pos_n;
    logic [`FPS_IRQ_W-1:0] ev;

    always_comb begin
        r_d = r_q;
        ev = '0;
        r_d.move.start = 1'b0;
        r_d.nv.wr = 1'b0;
        r_d.check_req = 1'b0;
        r_d.rd_data = '0;
        r_d.prev_in = lvl;
        r_d.prev_pwr = pwr_s;
        // Register writes
        if (bus.wr) begin
            unique case (bus.addr)
                `FPS_REG_CTRL: begin
                    r_d.cfg.tracking_enable = bus.wdata[`FPS_CTRL_TRACK];
                    r_d.cfg.step_forward_en = bus.wdata[`FPS_CTRL_FWD_EN];
                    r_d.cfg.step_backward_en = bus.wdata[`FPS_CTRL_BACK_EN];
                    r_d.cfg.step_home_en = bus.wdata[`FPS_CTRL_HOME_EN];
                    r_d.cfg.multi_turn = bus.wdata[`FPS_CTRL_MULTI];
                    r_d.check_req = bus.wdata[`FPS_CTRL_CHECK];
                end
                `FPS_REG_MAP: r_d.cfg.map = bus.wdata[27:0];
                `FPS_REG_RES: r_d.cfg.res = bus.wdata;
                `FPS_REG_TURNS: r_d.cfg.virtual_turn_count = bus.wdata;
                `FPS_REG_MODULO: r_d.cfg.modulo_range = bus.wdata;
                `FPS_REG_FACTOR: r_d.cfg.encoder_turn_factor = bus.wdata;
                `FPS_REG_GNUM: r_d.cfg.gear_numerator = bus.wdata;
                `FPS_REG_GDEN: r_d.cfg.gear_denominator = bus.wdata;
                `FPS_REG_IRQ_MASK: r_d.irq_mask = bus.wdata[`FPS_IRQ_W-1:0];
                default: ;
            endcase
        end
        // Move sequencing
        unique case (r_q.mode)
            FPS_IDLE: ;
            FPS_LAUNCH: r_d.mode = FPS_MOVING;
            FPS_MOVING: begin
                if (!motion_busy) begin
                    r_d.mode = FPS_IDLE;
                    r_d.cur_tgt = r_q.cmd_tgt; // RL10
                    ev[`FPS_IRQ_DONE] = 1'b1;
                end
            end
        endcase
        if (trg_rise) begin
            r_d.cmd_tgt = sel_idx; // RL3
            r_d.mode = FPS_LAUNCH;
        end else if (home_ok) begin
            r_d.cmd_tgt = `FPS_TGT_FIRST; // RL6
            r_d.mode = FPS_LAUNCH;
        end else if (fwd_ok) begin
            r_d.cmd_tgt = r_q.cur_tgt + 4'h1; // RL4
            r_d.mode = FPS_LAUNCH;
        end else if (back_ok) begin
            r_d.cmd_tgt = r_q.cur_tgt - 4'h1; // RL5
            r_d.mode = FPS_LAUNCH;
        end
        if (r_d.mode == FPS_LAUNCH) begin
            r_d.move.start = 1'b1;
            r_d.move.target = r_d.cmd_tgt;
            ev[`FPS_IRQ_START] = 1'b1;
        end
        // Position range, saturated to 32 bits
        range_full = 64'(r_q.cfg.res);
        if (r_q.cfg.tracking_enable) begin
            range_full = range_full * 64'(r_q.cfg.virtual_turn_count); // RL12
        end
        r_d.range = (range_full[63:32] != '0) ? 32'hFFFF_FFFF
            : range_full[31:0]; // RL13
        // Position accumulation with single-turn wrap
        delta = 34'(signed'({2'b00, enc_pos})) -
            34'(signed'({2'b00, r_q.enc_prev}));
        half = 34'(signed'({2'b00, r_q.cfg.res >> 1}));
        if (delta > half) begin
            delta = delta - 34'(signed'({2'b00, r_q.cfg.res}));
        end else if (delta < -half) begin
            delta = delta + 34'(signed'({2'b00, r_q.cfg.res}));
        end
        pos_n = 34'(signed'({2'b00, r_q.act_pos})) + delta;
        if (pos_n >= 34'(signed'({2'b00, r_q.range}))) begin
            pos_n = pos_n - 34'(signed'({2'b00, r_q.range}));
        end else if (pos_n < 34'sh0) begin
            pos_n = pos_n + 34'(signed'({2'b00, r_q.range}));
        end
        r_d.act_pos = pos_n[31:0]; // RL13
        r_d.enc_prev = enc_pos;
        // Power-up tolerance check on saved position
        if (r_q.check_req) begin
            if (r_q.cfg.tracking_enable && check_fail) begin
                r_d.trk_flt = 1'b1; // RL14
                r_d.check_ok = 1'b0;
                ev[`FPS_IRQ_TRK] = 1'b1;
            end else begin
                r_d.act_pos = enc_pos; // RL11 RL14
                r_d.check_ok = 1'b1;
                r_d.trk_flt = 1'b0;
            end
        end
        // Store position at power-off
        if (pwr_rise && r_q.cfg.tracking_enable) begin
            r_d.nv.wr = 1'b1; // RL11
            r_d.nv.data = r_q.act_pos;
        end
        r_d.ratio_flt = ratio_bad; // RL15 RL16
        if (ratio_bad && !r_q.ratio_flt) begin
            ev[`FPS_IRQ_RATIO] = 1'b1;
        end
        // Reads, with read-to-clear of interrupt status
        if (bus.rd) begin
            unique case (bus.addr)
                `FPS_REG_CTRL: r_d.rd_data = {26'h0, 1'b0, r_q.cfg.multi_turn,
                    r_q.cfg.step_home_en, r_q.cfg.step_backward_en,
                    r_q.cfg.step_forward_en, r_q.cfg.tracking_enable};
                `FPS_REG_MAP: r_d.rd_data = {4'h0, r_q.cfg.map};
                `FPS_REG_RES: r_d.rd_data = r_q.cfg.res;
                `FPS_REG_TURNS: r_d.rd_data = r_q.cfg.virtual_turn_count;
                `FPS_REG_MODULO: r_d.rd_data = r_q.cfg.modulo_range;
                `FPS_REG_FACTOR: r_d.rd_data = r_q.cfg.encoder_turn_factor;
                `FPS_REG_GNUM: r_d.rd_data = r_q.cfg.gear_numerator;
                `FPS_REG_GDEN: r_d.rd_data = r_q.cfg.gear_denominator;
                `FPS_REG_STATUS: r_d.rd_data = {20'h0, r_q.check_ok,
                    r_q.ratio_flt, r_q.trk_flt, r_q.mode != FPS_IDLE,
                    r_q.cmd_tgt, r_q.cur_tgt};
                `FPS_REG_ACTPOS: r_d.rd_data = r_q.act_pos;
                `FPS_REG_RANGE: r_d.rd_data = r_q.range;
                `FPS_REG_IRQ_STAT: begin
                    r_d.rd_data = {28'h0, r_q.irq_stat};
                    r_d.irq_stat = '0;
                end
                `FPS_REG_IRQ_MASK: r_d.rd_data = {28'h0, r_q.irq_mask};
                default: r_d.rd_data = '0;
            endcase
        end
        // Set wins over read-clear
        r_d.irq_stat = r_d.irq_stat | ev;
        r_d.irq = |(r_d.irq_stat & r_d.irq_mask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r_q <= '0;
            r_q.cfg.map <= 28'(`FPS_MAP_RESET); // RL17
            r_q.cfg.res <= `FPS_RES_RESET;
            r_q.cfg.virtual_turn_count <= `FPS_TURNS_RESET;
            r_q.cfg.modulo_range <= `FPS_ONE_RESET;
            r_q.cfg.encoder_turn_factor <= `FPS_ONE_RESET;
            r_q.cfg.gear_numerator <= `FPS_ONE_RESET;
            r_q.cfg.gear_denominator <= `FPS_ONE_RESET;
            r_q.range <= `FPS_RES_RESET;
            r_q.cur_tgt <= `FPS_TGT_FIRST;
            r_q.cmd_tgt <= `FPS_TGT_FIRST;
            r_q.move.target <= `FPS_TGT_FIRST;
        end else begin
            r_q <= r_d;
        end
    end

    assign rd_data = r_q.rd_data;
    assign move = r_q.move;
    assign nv = r_q.nv;
    assign tracking_tolerance_fault = r_q.trk_flt;
    assign ratio_fault = r_q.ratio_flt;
    assign irq = r_q.irq;

    // Checks
    sequence s_trg_seen;
        trg_rise;
    endsequence
    sequence s_started(logic [3:0] t);
        move.start && (move.target == t);
    endsequence
    property positioning_trigger_start;
        @(posedge sys_clk) disable iff (rst)
        s_trg_seen |=> s_started($past(sel_idx));
    endproperty
    a_trg_start: assert property (positioning_trigger_start) // RL1 RL3
        else $error("trigger edge did not start selected move");
    property p_sel2_off;
        @(posedge sys_clk) disable iff (rst)
        (r_q.cfg.map.sel2 == 4'h0) |-> (sel_idx <= 4'h4);
    endproperty
    a_sel2_off: assert property (p_sel2_off) // RL2
        else $error("unmapped third select reached upper targets");
    property p_fwd;
        @(posedge sys_clk) disable iff (rst)
        (fwd_ok && !trg_rise && !home_ok)
            |=> s_started($past(r_q.cur_tgt) + 4'h1);
    endproperty
    a_fwd: assert property (p_fwd) // RL4
        else $error("step forward target wrong");
    property p_back;
        @(posedge sys_clk) disable iff (rst)
        (back_ok && !trg_rise && !home_ok && !fwd_ok)
            |=> s_started($past(r_q.cur_tgt) - 4'h1);
    endproperty
    a_back: assert property (p_back) // RL5
        else $error("step backward target wrong");
    property p_home;
        @(posedge sys_clk) disable iff (rst)
        (home_ok && !trg_rise) |=> s_started(`FPS_TGT_FIRST);
    endproperty
    a_home: assert property (p_home) // RL6 RL9
        else $error("step home did not go to target one");
    property p_busy_ignore;
        @(posedge sys_clk) disable iff (rst)
        (r_q.mode != FPS_IDLE && !trg_rise) |=> !move.start;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) // RL7 RL19
        else $error("step edge acted during motion");
    property p_last;
        @(posedge sys_clk) disable iff (rst)
        (r_q.cur_tgt == `FPS_TGT_LAST && r_q.mode == FPS_IDLE
            && rise == 4'b0010) |=> !move.start;
    endproperty
    a_last: assert property (p_last) // RL8
        else $error("step forward acted at last target");
    property p_end_move;
        @(posedge sys_clk) disable iff (rst)
        (r_q.mode == FPS_MOVING && !motion_busy && !trg_rise)
            |=> (r_q.cur_tgt == $past(r_q.cmd_tgt)) && r_q.mode == FPS_IDLE;
    endproperty
    a_end_move: assert property (p_end_move) // RL10
        else $error("current target not taken from commanded target");
    property p_store;
        @(posedge sys_clk) disable iff (rst)
        (pwr_rise && r_q.cfg.tracking_enable)
            |=> nv.wr && (nv.data == $past(r_q.act_pos)) ##1 !nv.wr;
    endproperty
    a_store: assert property (p_store) // RL11
        else $error("position not stored at power-off");
    property p_check;
        @(posedge sys_clk) disable iff (rst)
        (r_q.check_req && r_q.cfg.tracking_enable && check_fail)
            |=> tracking_tolerance_fault && !r_q.check_ok;
    endproperty
    a_check: assert property (p_check) // RL14
        else $error("tolerance fault missing");
    property p_ratio;
        @(posedge sys_clk) disable iff (rst)
        ratio_bad |=> ratio_fault;
    endproperty
    a_ratio: assert property (p_ratio) // RL15 RL16
        else $error("ratio fault missing");
    property p_edge_once;
        @(posedge sys_clk) disable iff (rst)
        trg_rise |=> !trg_rise;
    endproperty
    a_edge_once: assert property (p_edge_once) // RL18
        else $error("trigger edge lasted more than one cycle");
endmodule
`default_nettype wire

// file: hw/fps_defines.svh
// Register map, field positions, reset values and constants
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

`define FPS_ADDR_W 6
`define FPS_REG_CTRL 6'h00
`define FPS_REG_MAP 6'h04
`define FPS_REG_RES 6'h08
`define FPS_REG_TURNS 6'h0C
`define FPS_REG_MODULO 6'h10
`define FPS_REG_FACTOR 6'h14
`define FPS_REG_GNUM 6'h18
`define FPS_REG_GDEN 6'h1C
`define FPS_REG_STATUS 6'h20
`define FPS_REG_ACTPOS 6'h24
`define FPS_REG_RANGE 6'h28
`define FPS_REG_IRQ_STAT 6'h2C
`define FPS_REG_IRQ_MASK 6'h30

// Control register bits
`define FPS_CTRL_TRACK 0
`define FPS_CTRL_FWD_EN 1
`define FPS_CTRL_BACK_EN 2
`define FPS_CTRL_HOME_EN 3
`define FPS_CTRL_MULTI 4
`define FPS_CTRL_CHECK 5

// Input map: one nibble per signal, 0 = not assigned, 1..8 = input n
`define FPS_MAP_RESET 32'h0000_6087
`define FPS_IN_COUNT 8

// Interrupt status bits
`define FPS_IRQ_START 0
`define FPS_IRQ_DONE 1
`define FPS_IRQ_TRK 2
`define FPS_IRQ_RATIO 3
`define FPS_IRQ_W 4

// Reset values of numeric settings
`define FPS_RES_RESET 32'h0000_1000
`define FPS_TURNS_RESET 32'h0000_0001
`define FPS_ONE_RESET 32'h0000_0001

// Target indices and multi-turn encoder count
`define FPS_TGT_FIRST 4'h1
`define FPS_TGT_LAST 4'h8
`define FPS_MT_COUNT 80'h1000
`define FPS_QUARTER_SHIFT 2

`endif

// file: hw/fps_pkg.sv
// Types shared by the fixed position setpoint block
`include "fps_defines.svh"
package fps_pkg;

    typedef enum logic [1:0] {
        FPS_IDLE,
        FPS_LAUNCH,
        FPS_MOVING
    } fps_mode_t;

    typedef struct packed {
        logic [`FPS_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } fps_bus_t;

    typedef struct packed {
        logic [3:0] step_home;
        logic [3:0] step_backward;
        logic [3:0] step_forward;
        logic [3:0] trg;
        logic [3:0] sel2;
        logic [3:0] sel1;
        logic [3:0] sel0;
    } fps_map_t;

    typedef struct packed {
        logic tracking_enable;
        logic step_forward_en;
        logic step_backward_en;
        logic step_home_en;
        logic multi_turn;
        fps_map_t map;
        logic [31:0] res;
        logic [31:0] virtual_turn_count;
        logic [31:0] modulo_range;
        logic [31:0] encoder_turn_factor;
        logic [31:0] gear_numerator;
        logic [31:0] gear_denominator;
    } fps_cfg_t;

    typedef struct packed {
        logic start;
        logic [3:0] target;
    } fps_move_t;

    typedef struct packed {
        logic wr;
        logic [31:0] data;
    } fps_nv_t;

    typedef struct packed {
        fps_cfg_t cfg;
        fps_mode_t mode;
        logic [3:0] cur_tgt;
        logic [3:0] cmd_tgt;
        logic [3:0] prev_in;
        logic prev_pwr;
        logic check_req;
        logic [31:0] enc_prev;
        logic [31:0] act_pos;
        logic [31:0] range;
        logic trk_flt;
        logic ratio_flt;
        logic check_ok;
        logic [`FPS_IRQ_W-1:0] irq_stat;
        logic [`FPS_IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] rd_data;
        fps_move_t move;
        fps_nv_t nv;
    } fps_state_t;

endpackage

// file: hw/fps_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module fps_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fps_sync_state_t;

    fps_sync_state_t r_q;
    fps_sync_state_t r_d;

    always_comb begin
        r_d.s1 = din;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign dout = r_q.s2;
endmodule
`default_nettype wire

// file: hw/fps_ratio_check.sv
// Integer check of multi-turn resolution over modulo range
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"
module fps_ratio_check (
    input wire fps_pkg::fps_cfg_t cfg,
    output logic ratio_bad
);
    import fps_pkg::*;

    logic [79:0] num;
    logic [63:0] den;
    logic [79:0] rem;

    always_comb begin
        num = 80'(cfg.encoder_turn_factor);
        den = 64'(cfg.modulo_range);
        rem = '0;
        if (cfg.tracking_enable) begin
            num = 80'(cfg.virtual_turn_count) * num;
        end else begin
            num = 80'(cfg.gear_numerator) * num;
            den = 64'(cfg.gear_denominator) * den;
            if (cfg.multi_turn) begin
                num = `FPS_MT_COUNT * num;
            end
        end
        if (den != '0) begin
            rem = num % 80'(den);
        end
        ratio_bad = (den == '0) || (rem != '0);
    end
endmodule
`default_nettype wire

// file: test/fps_ctl_model.sv
// Controller model driving the select, trigger and step input pins
`timescale 1ns/1ps
`default_nettype none
module fps_ctl_model (
    input wire logic sys_clk,
    output logic [7:0] digital_in
);
    initial digital_in = 8'h00;

    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Selection settles before any trigger edge
    task automatic select(input logic [2:0] code, input logic [7:0] other);
        @(posedge sys_clk);
        digital_in <= (other & 8'h10) | {code[1], code[0], 5'h00, code[2]};
        hold(3);
    endtask

    // Rising edge on input n, then back low
    task automatic pulse(input int n);
        @(posedge sys_clk);
        digital_in[n-1] <= 1'b1;
        hold(4);
        digital_in[n-1] <= 1'b0;
        hold(4);
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking testbench for the fixed position setpoint block
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"
module tb;
    import fps_pkg::*;
    logic sys_clk, rst, power_fail, motion_busy, motor_standstill, irq;
    logic tracking_tolerance_fault, ratio_fault;
    logic [31:0] enc_pos, nv_rd_data, rd_data, rdv, nv_last, m;
    logic [7:0] digital_in;
    logic [3:0] last_tgt;
    fps_bus_t bus;
    fps_move_t move;
    fps_nv_t nv;
    int failures, checked, starts, nvw, s0, seed, kind;

    fps_top u_dut (.sys_clk(sys_clk), .rst(rst), .digital_in(digital_in),
        .power_fail(power_fail), .motion_busy(motion_busy),
        .motor_standstill(motor_standstill), .enc_pos(enc_pos),
        .nv_rd_data(nv_rd_data), .bus(bus), .rd_data(rd_data),
        .move(move), .nv(nv), .ratio_fault(ratio_fault), .irq(irq),
        .tracking_tolerance_fault(tracking_tolerance_fault));
    fps_ctl_model u_ctl (.sys_clk(sys_clk), .digital_in(digital_in));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (move.start === 1'b1) begin
            starts++;
            last_tgt = move.target;
        end
        if (nv.wr === 1'b1) begin
            nvw++;
            nv_last = nv.data;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask

    function automatic logic [3:0] exp_tgt(input logic [2:0] code);
        return 4'(code) + 4'h1;
    endfunction

    function automatic logic exp_bad(input int k, input longint t,
        input longint md);
        longint num;
        num = (k == 2) ? t : ((k == 1) ? 4096 : 1);
        return (num % md) != 0;
    endfunction

    task automatic trig(input logic [2:0] code, input logic [3:0] exp);
        s0 = starts;
        u_ctl.select(code, 8'($random(seed)));
        u_ctl.pulse(6);
        cyc(2);
        chk(32'(starts - s0), 32'h1);
        chk({28'h0, last_tgt}, {28'h0, exp});
    endtask

    task automatic step(input int pin, input int n, input logic [3:0] exp);
        s0 = starts;
        u_ctl.pulse(pin);
        cyc(2);
        chk(32'(starts - s0), 32'(n));
        if (n == 1)
            chk({28'h0, last_tgt}, {28'h0, exp});
    endtask

    task automatic give_verdict;
        $display("Checks %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        $display("Error at %0t: run did not finish", $time);
        give_verdict;
    end

    initial begin
        seed = 32'hCC2A8FD3;
        rst = 1'b1;
        power_fail = 1'b0;
        motion_busy = 1'b0;
        motor_standstill = 1'b1;
        enc_pos = 32'h0;
        nv_rd_data = 32'h0;
        bus = '0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(1);
        chk({28'h0, move.target}, 32'h1);
        rd(`FPS_REG_MAP, rdv);
        chk(rdv, 32'h0000_6087);
        rd(6'h3C, rdv);
        chk(rdv, 32'h0);
        for (int i = 0; i < 8; i++)
            trig(3'(i), exp_tgt({1'b0, 2'(i)}));
        $display("Test default map done");
        wr(`FPS_REG_MAP, 32'h0432_6187);
        wr(`FPS_REG_CTRL, 32'h0000_000E);
        for (int i = 0; i < 8; i++)
            trig(3'(i), exp_tgt(3'(i)));
        step(2, 0, 4'h0);
        step(3, 1, 4'h7);
        step(4, 1, 4'h1);
        step(3, 0, 4'h0);
        step(4, 1, 4'h1);
        step(2, 1, 4'h2);
        @(posedge sys_clk);
        motion_busy <= 1'b1;
        motor_standstill <= 1'b0;
        trig(3'h4, 4'h5);
        step(2, 0, 4'h0);
        @(posedge sys_clk);
        motion_busy <= 1'b0;
        motor_standstill <= 1'b1;
        cyc(4);
        chk(32'(starts - s0), 32'h0);
        rd(`FPS_REG_STATUS, rdv);
        chk({28'h0, rdv[3:0]}, 32'h5);
        $display("Test steps done");
        rd(`FPS_REG_IRQ_STAT, rdv);
        wr(`FPS_REG_IRQ_MASK, 32'h3);
        trig(3'h0, 4'h1);
        chk({31'h0, irq}, 32'h1);
        rd(`FPS_REG_IRQ_STAT, rdv);
        chk(rdv & 32'h3, 32'h3);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(`FPS_REG_IRQ_MASK, 32'h0);
        trig(3'h1, 4'h2);
        chk({31'h0, irq}, 32'h0);
        $display("Test interrupt done");
        @(posedge sys_clk);
        nv_rd_data <= 32'h100;
        enc_pos <= 32'h500;
        wr(`FPS_REG_TURNS, 32'h18);
        wr(`FPS_REG_CTRL, 32'h0000_002F);
        cyc(3);
        rd(`FPS_REG_ACTPOS, rdv);
        chk(rdv, 32'h500);
        chk({31'h0, tracking_tolerance_fault}, 32'h0);
        rd(`FPS_REG_RANGE, rdv);
        chk(rdv, 32'h0001_8000);
        @(posedge sys_clk);
        power_fail <= 1'b1;
        cyc(6);
        chk(32'(nvw), 32'h1);
        chk(nv_last, 32'h500);
        @(posedge sys_clk);
        enc_pos <= 32'h501;
        wr(`FPS_REG_CTRL, 32'h0000_002F);
        cyc(3);
        chk({31'h0, tracking_tolerance_fault}, 32'h1);
        wr(`FPS_REG_TURNS, 32'h0010_0000);
        rd(`FPS_REG_RANGE, rdv);
        chk(rdv, 32'hFFFF_FFFF);
        wr(`FPS_REG_CTRL, 32'h0000_000E);
        rd(`FPS_REG_RANGE, rdv);
        chk(rdv, 32'h0000_1000);
        for (int i = 0; i < 9; i++) begin
            kind = i % 3;
            m = (i < 3) ? 32'h3 : (i < 6) ? 32'h1 : 32'h1 + ($random(seed) & 7);
            wr(`FPS_REG_MODULO, m);
            wr(`FPS_REG_CTRL, 32'h0E | ((kind == 1) ? 32'h10 : 32'h0) |
                ((kind == 2) ? 32'h1 : 32'h0));
            cyc(3);
            chk({31'h0, ratio_fault},
                {31'h0, exp_bad(kind, 64'h10_0000, 64'(m))});
        end
        $display("Test tracking done");
        give_verdict;
    end
endmodule
`default_nettype wire
